// ### pkg/pflag_pkg.sv
// Package for the peripheral interrupt flag bank: register map, bit positions, reset values.
// Assumes a 32-bit APB slave on a single 250 MHz clock.
package pflag_pkg;
    localparam logic [7:0] PFLAG_ADDR_FLAGS_ONE = 8'h00;
    localparam logic [7:0] PFLAG_ADDR_FLAGS_TWO = 8'h04;
    localparam logic [7:0] PFLAG_ADDR_MASK_ONE = 8'h08;
    localparam logic [7:0] PFLAG_ADDR_MASK_TWO = 8'h0C;
    localparam logic [7:0] PFLAG_ADDR_CAPCOMP_MODE = 8'h10;

    localparam int PFLAG_BIT_PARPORT = 7;
    localparam int PFLAG_BIT_CONV = 6;
    localparam int PFLAG_BIT_RX = 5;
    localparam int PFLAG_BIT_TX = 4;
    localparam int PFLAG_BIT_SYNC = 3;
    localparam int PFLAG_BIT_CC1 = 2;
    localparam int PFLAG_BIT_TIMER_TWO_COUNT = 1;
    localparam int PFLAG_BIT_TIMER_ONE_COUNT = 0;
    localparam int PFLAG_BIT_OSC = 7;
    localparam int PFLAG_BIT_CMP = 6;
    localparam int PFLAG_BIT_BCOL = 3;
    localparam int PFLAG_BIT_VDET = 2;
    localparam int PFLAG_BIT_TMR3 = 1;
    localparam int PFLAG_BIT_CC2 = 0;

    // Software-clearable bits; rx/tx in register one are live status
    localparam logic [7:0] PFLAG_W1C_ONE = 8'hCF;
    localparam logic [7:0] PFLAG_IMPL_TWO = 8'hCF;
    localparam logic [7:0] PFLAG_RESET_FLAGS = 8'h00;
    localparam logic [7:0] PFLAG_RESET_MASK = 8'h00;
    localparam logic [31:0] PFLAG_RDATA_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        PFLAG_MODE_CAPTURE = 2'b00,
        PFLAG_MODE_COMPARE = 2'b01,
        PFLAG_MODE_PWM = 2'b11,
        PFLAG_MODE_OFF = 2'b10
    } pflag_ccmode_t;

    typedef struct packed {
        logic parport_access;
        logic conv_done;
        logic rx_full;
        logic tx_empty;
        logic sync_done;
        logic cc1_capture;
        logic cc1_match;
        logic timer_two_count_match;
        logic timer_one_count_overflow;
        logic osc_fail;
        logic cmp_change;
        logic bus_collision;
        logic volt_detect;
        logic tmr3_overflow;
        logic cc2_capture;
        logic cc2_match;
    } pflag_events_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } pflag_apb_req_t;
endpackage

// ### rtl/pflag_bank.sv
// Peripheral interrupt request flag bank with APB register access.
// Assumes event inputs are one-cycle pulses or levels from logic on i_clock;
// oscillator-fail and comparator output arrive asynchronously and are synchronised here.
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps

// Summary of operation
// - Two separate eight-bit flag registers
// - Flags set regardless of the mask registers; none set while i_clk_en is low
// - Bit 7 sets on parallel port access
// - Small package: parallel port flag reads zero
// - Bit 6 sets on conversion done
// - Bit 5 shows receive buffer full, read-only
// - Bit 4 shows transmit buffer empty, read-only
// - Bit 3 sets on sync serial done
// - Capture mode: bit 2 sets on capture
// - Compare mode: bit 2 sets on match
// - PWM mode: unit never sets bit 2
// - Bit 1 sets on timer two match
// - Bit 0 sets on timer one overflow
// - Register two: bits 5-4 zero; timer three, capcomp two
module pflag_bank
    import pflag_pkg::*;
#(
    parameter bit SMALL_PACKAGE = 1'b0,
    parameter int ADDR_WIDTH = 8
) (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [ADDR_WIDTH-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire pflag_events_t i_events,
    input wire logic i_osc_fail_async,
    input wire logic i_cmp_out_async,
    output logic [7:0] o_flags_one,
    output logic [7:0] o_flags_two,
    output logic o_irq
);
    generate
        if (ADDR_WIDTH != 8)
        begin : g_bad_width
            $error("pflag_bank: ADDR_WIDTH must be 8");
        end
    endgenerate

    pflag_apb_req_t req;
    logic [1:0] async_sync;
    logic cmp_prev_ff;
    logic [7:0] flags_one_ff;
    logic [7:0] flags_two_ff;
    logic [7:0] mask_one_ff;
    logic [7:0] mask_two_ff;
    pflag_ccmode_t cc1_mode_ff;
    pflag_ccmode_t cc2_mode_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic irq_ff;
    logic [7:0] nxt_flags_one;
    logic [7:0] nxt_flags_two;
    logic [7:0] nxt_mask_one;
    logic [7:0] nxt_mask_two;
    pflag_ccmode_t nxt_cc1_mode;
    pflag_ccmode_t nxt_cc2_mode;
    logic [31:0] nxt_prdata;
    logic nxt_pready;
    logic nxt_pslverr;
    logic nxt_irq;
    logic [7:0] set_one;
    logic [7:0] set_two;
    logic [7:0] clr_one;
    logic [7:0] clr_two;
    logic wr_access;
    logic rd_access;
    logic addr_hit;
    logic cmp_edge;

    assign req = '{psel: i_psel, penable: i_penable, pwrite: i_pwrite, paddr: i_paddr, pwdata: i_pwdata};

    pflag_sync #(
        .WIDTH(2)
    ) u_sync (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_enable(i_clk_en),
        .i_async({i_osc_fail_async, i_cmp_out_async}),
        .o_sync(async_sync)
    );

    // Comparator change caught on any edge of the synchronised output
    assign cmp_edge = async_sync[0] ^ cmp_prev_ff;

    // Access phase takes two cycles; pready rises the cycle after the first penable cycle
    assign wr_access = req.psel && req.penable && req.pwrite && !pready_ff;
    assign rd_access = req.psel && req.penable && !req.pwrite && !pready_ff;
    assign addr_hit = (req.paddr == PFLAG_ADDR_FLAGS_ONE) || (req.paddr == PFLAG_ADDR_FLAGS_TWO)
        || (req.paddr == PFLAG_ADDR_MASK_ONE) || (req.paddr == PFLAG_ADDR_MASK_TWO)
        || (req.paddr == PFLAG_ADDR_CAPCOMP_MODE);

    always_comb
    begin
        set_one = '0;
        set_two = '0;
        set_one[PFLAG_BIT_PARPORT] = i_events.parport_access && !SMALL_PACKAGE;
        set_one[PFLAG_BIT_CONV] = i_events.conv_done;
        set_one[PFLAG_BIT_SYNC] = i_events.sync_done;
        case (cc1_mode_ff)
            PFLAG_MODE_CAPTURE: set_one[PFLAG_BIT_CC1] = i_events.cc1_capture;
            PFLAG_MODE_COMPARE: set_one[PFLAG_BIT_CC1] = i_events.cc1_match;
            default: set_one[PFLAG_BIT_CC1] = 1'b0;
        endcase
        set_one[PFLAG_BIT_TIMER_TWO_COUNT] = i_events.timer_two_count_match;
        set_one[PFLAG_BIT_TIMER_ONE_COUNT] = i_events.timer_one_count_overflow;
        set_two[PFLAG_BIT_OSC] = async_sync[1];
        set_two[PFLAG_BIT_CMP] = cmp_edge;
        set_two[PFLAG_BIT_BCOL] = i_events.bus_collision;
        set_two[PFLAG_BIT_VDET] = i_events.volt_detect;
        set_two[PFLAG_BIT_TMR3] = i_events.tmr3_overflow;
        case (cc2_mode_ff)
            PFLAG_MODE_CAPTURE: set_two[PFLAG_BIT_CC2] = i_events.cc2_capture;
            PFLAG_MODE_COMPARE: set_two[PFLAG_BIT_CC2] = i_events.cc2_match;
            default: set_two[PFLAG_BIT_CC2] = 1'b0;
        endcase
    end

    always_comb
    begin
        clr_one = '0;
        clr_two = '0;
        nxt_mask_one = mask_one_ff;
        nxt_mask_two = mask_two_ff;
        nxt_cc1_mode = cc1_mode_ff;
        nxt_cc2_mode = cc2_mode_ff;
        nxt_pready = 1'b0;
        nxt_pslverr = 1'b0;
        nxt_prdata = PFLAG_RDATA_ZERO;
        if (req.psel && req.penable && !pready_ff)
        begin
            nxt_pready = 1'b1;
            nxt_pslverr = !addr_hit;
        end
        if (wr_access && i_pstrb[0])
        begin
            case (req.paddr)
                PFLAG_ADDR_FLAGS_ONE: clr_one = req.pwdata[7:0] & PFLAG_W1C_ONE;
                PFLAG_ADDR_FLAGS_TWO: clr_two = req.pwdata[7:0];
                PFLAG_ADDR_MASK_ONE: nxt_mask_one = req.pwdata[7:0];
                PFLAG_ADDR_MASK_TWO: nxt_mask_two = req.pwdata[7:0];
                PFLAG_ADDR_CAPCOMP_MODE:
                begin
                    nxt_cc1_mode = pflag_ccmode_t'(req.pwdata[1:0]);
                    nxt_cc2_mode = pflag_ccmode_t'(req.pwdata[3:2]);
                end
                default: clr_one = '0;
            endcase
        end
        if (rd_access)
        begin
            case (req.paddr)
                PFLAG_ADDR_FLAGS_ONE: nxt_prdata = {24'h00_0000, flags_one_ff};
                PFLAG_ADDR_FLAGS_TWO: nxt_prdata = {24'h00_0000, flags_two_ff};
                PFLAG_ADDR_MASK_ONE: nxt_prdata = {24'h00_0000, mask_one_ff};
                PFLAG_ADDR_MASK_TWO: nxt_prdata = {24'h00_0000, mask_two_ff};
                PFLAG_ADDR_CAPCOMP_MODE: nxt_prdata = {28'h000_0000, cc2_mode_ff, cc1_mode_ff};
                default: nxt_prdata = PFLAG_RDATA_ZERO;
            endcase
        end
    end

    always_comb
    begin
        nxt_flags_one = (flags_one_ff & ~clr_one) | set_one;
        nxt_flags_two = ((flags_two_ff & ~clr_two) | set_two) & PFLAG_IMPL_TWO;
        nxt_flags_one[PFLAG_BIT_RX] = i_events.rx_full;
        nxt_flags_one[PFLAG_BIT_TX] = i_events.tx_empty;
        if (SMALL_PACKAGE)
        begin
            nxt_flags_one[PFLAG_BIT_PARPORT] = 1'b0;
        end
        nxt_irq = |(nxt_flags_one & mask_one_ff) || |(nxt_flags_two & mask_two_ff);
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_reset_n)
        begin
            flags_one_ff <= PFLAG_RESET_FLAGS;
            flags_two_ff <= PFLAG_RESET_FLAGS;
            mask_one_ff <= PFLAG_RESET_MASK;
            mask_two_ff <= PFLAG_RESET_MASK;
            cc1_mode_ff <= PFLAG_MODE_CAPTURE;
            cc2_mode_ff <= PFLAG_MODE_CAPTURE;
            cmp_prev_ff <= 1'b0;
            prdata_ff <= PFLAG_RDATA_ZERO;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            irq_ff <= 1'b0;
        end
        else if (i_clk_en)
        begin
            flags_one_ff <= nxt_flags_one;
            flags_two_ff <= nxt_flags_two;
            mask_one_ff <= nxt_mask_one;
            mask_two_ff <= nxt_mask_two;
            cc1_mode_ff <= nxt_cc1_mode;
            cc2_mode_ff <= nxt_cc2_mode;
            cmp_prev_ff <= async_sync[0];
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            irq_ff <= nxt_irq;
        end
    end

    assign o_prdata = prdata_ff;
    assign o_pready = pready_ff;
    assign o_pslverr = pslverr_ff;
    assign o_flags_one = flags_one_ff;
    assign o_flags_two = flags_two_ff;
    assign o_irq = irq_ff;

    // Checks
    a_conv_sets: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        (i_clk_en && i_events.conv_done) |=> flags_one_ff[PFLAG_BIT_CONV])
        else $error("conversion flag not set");
    a_set_beats_clear: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        (i_clk_en && i_events.timer_one_count_overflow && wr_access && req.paddr == PFLAG_ADDR_FLAGS_ONE)
        |=> flags_one_ff[PFLAG_BIT_TIMER_ONE_COUNT])
        else $error("event lost on clear");
    a_flag_sticky: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        (i_clk_en && flags_one_ff[PFLAG_BIT_SYNC] && !(wr_access && i_pstrb[0]))
        |=> flags_one_ff[PFLAG_BIT_SYNC])
        else $error("sticky flag dropped");
    a_rx_live: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        i_clk_en |=> flags_one_ff[PFLAG_BIT_RX] == $past(i_events.rx_full))
        else $error("rx flag not tracking");
    a_tx_live: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        i_clk_en |=> flags_one_ff[PFLAG_BIT_TX] == $past(i_events.tx_empty))
        else $error("tx flag not tracking");
    a_pwm_quiet: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        (i_clk_en && cc1_mode_ff == PFLAG_MODE_PWM && !flags_one_ff[PFLAG_BIT_CC1])
        |=> !flags_one_ff[PFLAG_BIT_CC1])
        else $error("pwm mode set capcomp flag");
    a_unimpl_zero: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        flags_two_ff[5:4] == 2'b00)
        else $error("unimplemented bits set");
    a_osc_latch: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        (i_clk_en && async_sync[1]) |=> flags_two_ff[PFLAG_BIT_OSC])
        else $error("oscillator fail not latched");
    a_small_pkg: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        SMALL_PACKAGE |-> !flags_one_ff[PFLAG_BIT_PARPORT])
        else $error("parallel flag on small package");
    a_apb_ready: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        (i_clk_en && req.psel && req.penable && !pready_ff) |=> pready_ff)
        else $error("pready late");
    a_parport_sets: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        (i_clk_en && i_events.parport_access && !SMALL_PACKAGE) |=> flags_one_ff[PFLAG_BIT_PARPORT])
        else $error("parallel port flag not set");
    a_capture_sets: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        (i_clk_en && cc1_mode_ff == PFLAG_MODE_CAPTURE && i_events.cc1_capture) |=> flags_one_ff[PFLAG_BIT_CC1])
        else $error("capture flag not set");
    a_compare_sets: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        (i_clk_en && cc1_mode_ff == PFLAG_MODE_COMPARE && i_events.cc1_match) |=> flags_one_ff[PFLAG_BIT_CC1])
        else $error("compare flag not set");
    a_period_sets: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        (i_clk_en && i_events.timer_two_count_match) |=> flags_one_ff[PFLAG_BIT_TIMER_TWO_COUNT])
        else $error("period match flag not set");
    a_overflow_sets: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        (i_clk_en && i_events.timer_one_count_overflow) |=> flags_one_ff[PFLAG_BIT_TIMER_ONE_COUNT])
        else $error("overflow flag not set");
    a_timer_three: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        (i_clk_en && i_events.tmr3_overflow) |=> flags_two_ff[PFLAG_BIT_TMR3])
        else $error("timer three flag not set");
    // Low enable must freeze both flag registers
    a_frozen_hold: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        (!i_clk_en && i_reset_n) |=> ($stable(flags_one_ff) && $stable(flags_two_ff)))
        else $error("flags moved while frozen");
endmodule

// ### rtl/pflag_sync.sv
// Two-stage synchroniser for a vector of asynchronous levels.
// Assumes inputs are levels that are stable for several clocks.
`timescale 1ns/1ps
module pflag_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_enable,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] stage_ff;
    logic [WIDTH-1:0] sync_ff;

    always_ff @(posedge i_clock)
    begin
        if (!i_reset_n)
        begin
            stage_ff <= '0;
            sync_ff <= '0;
        end
        else if (i_enable)
        begin
            stage_ff <= i_async;
            sync_ff <= stage_ff;
        end
    end

    assign o_sync = sync_ff;
endmodule

// ### test/pflag_bank_test.sv
// Self-checking bench for the flag bank over APB, with a peripheral model.
// Assumes a one-wait-state APB slave and registered flag outputs.
`timescale 1ns/1ps
module pflag_bank_test
    import pflag_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [7:0] s_f1;
    logic [7:0] f1;
    logic [7:0] f2;
    logic clk_en = 1'b1;
    logic [3:0] pstrb = 4'hF;
    pflag_events_t ev;
    logic osc;
    logic cmp;
    logic [31:0] rdv;
    logic errv;
    int err_total = 0;
    int checked = 0;
    int evb[10] = '{15, 14, 11, 10, 8, 7, 4, 3, 2, 1};
    int fb[10] = '{7, 6, 3, 2, 1, 0, 3, 2, 1, 0};
    pflag_ccmode_t md[4] = '{PFLAG_MODE_CAPTURE, PFLAG_MODE_COMPARE, PFLAG_MODE_PWM, PFLAG_MODE_OFF};
    logic ecap[4] = '{1'b1, 1'b0, 1'b0, 1'b0};
    logic emat[4] = '{1'b0, 1'b1, 1'b0, 1'b0};
    logic [7:0] a;

    always #2 clk = ~clk;

    pflag_periph_model u_pflag_periph_model (.i_clock(clk), .o_events(ev), .o_osc_fail(osc), .o_cmp_out(cmp));

    pflag_bank u_pflag_bank (.i_clock(clk), .i_reset_n(rst_n), .i_clk_en(clk_en), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_events(ev), .i_osc_fail_async(osc),
        .i_cmp_out_async(cmp), .o_flags_one(f1), .o_flags_two(f2), .o_irq(irq));

    // Shares the bus but its answers are ignored
    pflag_bank #(.SMALL_PACKAGE(1'b1)) u_pflag_bank_small (.i_clock(clk), .i_reset_n(rst_n), .i_clk_en(clk_en),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .i_pstrb(pstrb), .o_prdata(), .o_pready(), .o_pslverr(), .i_events(ev), .i_osc_fail_async(osc),
        .i_cmp_out_async(cmp), .o_flags_one(s_f1), .o_flags_two(), .o_irq());

    task automatic test_done();
        if (err_total == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic xfer(input logic wr, input logic [7:0] ad, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
        begin
            n++;
            if (n > 20)
            begin
                err_total++;
                test_done();
            end
            @(posedge clk);
        end
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        xfer(1'b1, ad, d);
    endtask

    task automatic rdc(input logic [7:0] ad, input logic [31:0] exp);
        xfer(1'b0, ad, 32'h0);
        chk(rdv, exp);
    endtask

    // Irq is registered behind the mask
    task automatic irqc(input logic exp);
        @(posedge clk);
        chk({31'h0, irq}, {31'h0, exp});
    endtask

    initial
    begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++) rdc(8'(4 * i), 32'h0);
        for (int i = 0; i < 10; i++)
        begin
            a = (i < 6) ? PFLAG_ADDR_FLAGS_ONE : PFLAG_ADDR_FLAGS_TWO;
            u_pflag_periph_model.pulse(16'h1 << evb[i]);
            rdc(a, 32'h1 << fb[i]);
            wr(a, 32'h1 << fb[i]);
            rdc(a, 32'h0);
        end
        for (int i = 0; i < 4; i++)
        begin
            wr(PFLAG_ADDR_CAPCOMP_MODE, {28'h0, md[i], md[i]});
            u_pflag_periph_model.pulse(16'h0402);
            rdc(PFLAG_ADDR_FLAGS_ONE, {29'h0, ecap[i], 2'b00});
            rdc(PFLAG_ADDR_FLAGS_TWO, {31'h0, ecap[i]});
            wr(PFLAG_ADDR_FLAGS_ONE, 32'h04);
            wr(PFLAG_ADDR_FLAGS_TWO, 32'h01);
            u_pflag_periph_model.pulse(16'h0201);
            rdc(PFLAG_ADDR_FLAGS_ONE, {29'h0, emat[i], 2'b00});
            rdc(PFLAG_ADDR_FLAGS_TWO, {31'h0, emat[i]});
            wr(PFLAG_ADDR_FLAGS_ONE, 32'h04);
            wr(PFLAG_ADDR_FLAGS_TWO, 32'h01);
        end
        wr(PFLAG_ADDR_CAPCOMP_MODE, 32'h0);
        u_pflag_periph_model.raise(16'h2000);
        rdc(PFLAG_ADDR_FLAGS_ONE, 32'h20);
        wr(PFLAG_ADDR_FLAGS_ONE, 32'h30);
        rdc(PFLAG_ADDR_FLAGS_ONE, 32'h20);
        u_pflag_periph_model.lower(16'h2000);
        rdc(PFLAG_ADDR_FLAGS_ONE, 32'h0);
        u_pflag_periph_model.raise(16'h1000);
        rdc(PFLAG_ADDR_FLAGS_ONE, 32'h10);
        u_pflag_periph_model.lower(16'h1000);
        rdc(PFLAG_ADDR_FLAGS_ONE, 32'h0);
        // Held events against a clear of the same bits
        u_pflag_periph_model.raise(16'h4080);
        wr(PFLAG_ADDR_FLAGS_ONE, 32'h41);
        rdc(PFLAG_ADDR_FLAGS_ONE, 32'h41);
        u_pflag_periph_model.lower(16'h4080);
        wr(PFLAG_ADDR_FLAGS_ONE, 32'h41);
        rdc(PFLAG_ADDR_FLAGS_ONE, 32'h0);
        // Flag set with the mask open, held while the mask closes and reopens, then cleared
        wr(PFLAG_ADDR_MASK_ONE, 32'h40);
        rdc(PFLAG_ADDR_MASK_ONE, 32'h40);
        irqc(1'b0);
        u_pflag_periph_model.pulse(16'h4000);
        irqc(1'b1);
        wr(PFLAG_ADDR_MASK_ONE, 32'h0);
        irqc(1'b0);
        wr(PFLAG_ADDR_MASK_ONE, 32'h40);
        irqc(1'b1);
        wr(PFLAG_ADDR_FLAGS_ONE, 32'h40);
        irqc(1'b0);
        u_pflag_periph_model.set_async(1'b1, 1'b0);
        repeat (4) @(posedge clk);
        rdc(PFLAG_ADDR_FLAGS_TWO, 32'h80);
        u_pflag_periph_model.set_async(1'b0, 1'b0);
        repeat (4) @(posedge clk);
        wr(PFLAG_ADDR_FLAGS_TWO, 32'h80);
        rdc(PFLAG_ADDR_FLAGS_TWO, 32'h0);
        u_pflag_periph_model.set_async(1'b0, 1'b1);
        repeat (5) @(posedge clk);
        rdc(PFLAG_ADDR_FLAGS_TWO, 32'h40);
        wr(PFLAG_ADDR_FLAGS_TWO, 32'h40);
        u_pflag_periph_model.set_async(1'b0, 1'b0);
        repeat (5) @(posedge clk);
        rdc(PFLAG_ADDR_FLAGS_TWO, 32'h40);
        wr(PFLAG_ADDR_FLAGS_TWO, 32'hFF);
        rdc(PFLAG_ADDR_FLAGS_TWO, 32'h0);
        xfer(1'b0, 8'h14, 32'h0);
        chk({31'h0, errv}, 32'h1);
        chk(rdv, 32'h0);
        xfer(1'b1, 8'h18, 32'hFF);
        chk({31'h0, errv}, 32'h1);
        rdc(PFLAG_ADDR_MASK_ONE, 32'h40);
        // Lane zero strobe off: the clear must not land
        u_pflag_periph_model.pulse(16'h0080);
        @(posedge clk);
        pstrb <= 4'hE;
        wr(PFLAG_ADDR_FLAGS_ONE, 32'h01);
        pstrb <= 4'hF;
        rdc(PFLAG_ADDR_FLAGS_ONE, 32'h01);
        wr(PFLAG_ADDR_FLAGS_ONE, 32'h01);
        rdc(PFLAG_ADDR_FLAGS_ONE, 32'h0);
        // Frozen enable: a strobe must leave no trace
        @(posedge clk);
        clk_en <= 1'b0;
        u_pflag_periph_model.pulse(16'h0100);
        repeat (2) @(posedge clk);
        chk({24'h0, f1}, 32'h0);
        clk_en <= 1'b1;
        rdc(PFLAG_ADDR_FLAGS_ONE, 32'h0);
        // Flag outputs, and the small package left untouched
        u_pflag_periph_model.pulse(16'h8002);
        @(posedge clk);
        chk({24'h0, f1}, 32'h80);
        chk({24'h0, f2}, 32'h01);
        chk({31'h0, s_f1[7]}, 32'h0);
        // Mid-run reset clears flags, masks and answers
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        chk({14'h0, f1, f2, irq, pready}, 32'h0);
        rdc(PFLAG_ADDR_MASK_ONE, 32'h0);
        test_done();
    end
endmodule

// ### test/pflag_periph_model.sv
// Peripheral side model: drives event levels and pulses into the flag bank.
// Assumes the bench calls its tasks one at a time, each change on a rising edge.
`timescale 1ns/1ps
module pflag_periph_model
    import pflag_pkg::*;
(
    input wire logic i_clock,
    output pflag_events_t o_events,
    output logic o_osc_fail,
    output logic o_cmp_out
);
    initial
    begin
        o_events = '0;
        o_osc_fail = 1'b0;
        o_cmp_out = 1'b0;
    end

    task automatic raise(input logic [15:0] m);
        @(posedge i_clock);
        o_events <= pflag_events_t'(o_events | m);
    endtask

    task automatic lower(input logic [15:0] m);
        @(posedge i_clock);
        o_events <= pflag_events_t'(o_events & ~m);
    endtask

    // One-cycle strobe, as timers and converters give
    task automatic pulse(input logic [15:0] m);
        raise(m);
        lower(m);
    endtask

    // Oscillator and comparator are unclocked sources
    task automatic set_async(input logic osc, input logic cmp);
        @(posedge i_clock);
        o_osc_fail <= osc;
        o_cmp_out <= cmp;
    endtask
endmodule
